// ==== src/pmd_pkg.sv ====
// Package for the program memory access decode block
// Functional notes
// - CPU is held idle for the whole of any program memory write.
// - Write completion releases the CPU to resume after the store.
// - Code writes need code_write_enable bit 7 set and fuse enabled.
// - Fuse disabled forces code_write_enable to 0 regardless of writes.
// - Code-write on routes data moves to code space in internal range.
// - Code-write plus signature select makes stores target signatures.
// - Code-write off: external, data-flash low page, code/signature reads.
// - Code-write on ignores data-flash enable; size sets internal top.
// - Program writes use the same page write protocol as data-flash.
package pmd_pkg;
   localparam logic [7:0]  MAC_OFFSET   = 8'h96;
   localparam logic [7:0]  MAC_RESET    = 8'h00;
   localparam int          CWE_BIT      = 7;
   localparam int          SIG_BIT      = 6;
   localparam int          DFE_BIT      = 5;
   localparam logic [7:0]  MAC_WMASK    = 8'hE0;
   localparam logic [15:0] DF_TOP       = 16'h00FF;
   localparam logic [15:0] SIG_TOP      = 16'h01FF;
   localparam logic [15:0] CODE_TOP_BIG = 16'h1FFF;
   localparam logic [15:0] CODE_TOP_SML = 16'h0FFF;
   localparam logic [7:0]  DATA_UNMAP   = 8'h00;

   typedef enum logic [4:0] {
      SPC_EXT_DATA  = 5'b00001,
      SPC_DATA_FL   = 5'b00010,
      SPC_CODE      = 5'b00100,
      SPC_EXT_CODE  = 5'b01000,
      SPC_SIG       = 5'b10000
   } pmd_space_e;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HOLD = 2'b10
   } pmd_state_e;

   typedef struct packed {
      logic        valid;
      logic        is_code_read;
      logic        is_write;
      logic [15:0] addr;
   } pmd_req_s;

   typedef struct packed {
      pmd_space_e  space;
      logic        start_write;
   } pmd_route_s;
endpackage : pmd_pkg

// ==== src/pmd_top.sv ====
// Program memory access decode with register slave and CPU hold
`timescale 1ns/1ps
module pmd_top
   import pmd_pkg::*;
#(
   parameter bit BIG_PART = 1'b1
)
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [7:0]  AVS_WRITEDATA,
   output logic      [7:0]  AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        FUSE_CODE_WRITE,
   input  wire pmd_req_s    CPU_REQ,
   input  wire logic        WRITE_DONE,
   output pmd_route_s       ROUTE,
   output logic             CPU_IDLE_REQ
);
   logic [15:0] code_top;
   logic        cwe_q;
   logic        sig_q;
   logic        dfe_q;
   logic        ack_q;
   logic [7:0]  rdata_q;
   pmd_state_e  st_q;
   pmd_route_s  route_q;
   pmd_route_s  route_d;
   logic        idle_q;

   assign code_top = BIG_PART ? CODE_TOP_BIG : CODE_TOP_SML;

   // Space that a data move or code read reaches for the current bits
   function automatic pmd_space_e decode(input logic cwe, input logic sig,
                                         input logic dfe, input logic code,
                                         input logic [15:0] a,
                                         input logic [15:0] top);
      pmd_space_e s;
      s = SPC_EXT_DATA;
      if (code)
      begin
         if (sig)
            s = SPC_SIG;
         else if (a <= top)
            s = SPC_CODE;
         else
            s = SPC_EXT_CODE;
      end
      else if (cwe)
      begin
         // Data-flash enable has no say here
         if (a <= top)
            s = sig ? SPC_SIG : SPC_CODE;
         else
            s = SPC_EXT_DATA;
      end
      else if (dfe && a <= DF_TOP)
         s = SPC_DATA_FL;
      else
         s = SPC_EXT_DATA;
      return s;
   endfunction : decode

   // One wait cycle per access keeps read data straight from a flip-flop
   always_ff @(posedge CLK)
   begin
      if (RST)
         ack_q <= 1'b0;
      else
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         AVS_WAITREQUEST <= 1'b1;
      else
         AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_q);
   end

   // Control bits; fuse gating is continuous, not only on write
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cwe_q <= MAC_RESET[CWE_BIT];
         sig_q <= MAC_RESET[SIG_BIT];
         dfe_q <= MAC_RESET[DFE_BIT];
      end
      else
      begin
         // Write lands on the edge that sees waitrequest low
         if (AVS_WRITE && ack_q && AVS_ADDRESS == MAC_OFFSET)
         begin
            cwe_q <= AVS_WRITEDATA[CWE_BIT] & FUSE_CODE_WRITE;
            sig_q <= AVS_WRITEDATA[SIG_BIT];
            dfe_q <= AVS_WRITEDATA[DFE_BIT];
         end
         else if (!FUSE_CODE_WRITE)
            cwe_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         rdata_q <= DATA_UNMAP;
      else if (AVS_READ && !ack_q)
         rdata_q <= (AVS_ADDRESS == MAC_OFFSET)
                    ? ({cwe_q, sig_q, dfe_q, 5'h00} & MAC_WMASK)
                    : DATA_UNMAP;
   end
   assign AVS_READDATA = rdata_q;

   always_comb
   begin
      route_d.space = decode(cwe_q & FUSE_CODE_WRITE, sig_q, dfe_q,
                             CPU_REQ.is_code_read, CPU_REQ.addr, code_top);
      // A program store is handed to the same page write engine as data-flash
      route_d.start_write = CPU_REQ.valid & CPU_REQ.is_write
                            & ~CPU_REQ.is_code_read & (st_q == ST_RUN)
                            & (route_d.space == SPC_CODE
                               || route_d.space == SPC_SIG);
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         route_q <= '{space: SPC_EXT_DATA, start_write: 1'b0};
      else
         route_q <= route_d;
   end
   assign ROUTE = route_q;

   // CPU held until the write engine reports completion
   always_ff @(posedge CLK)
   begin
      if (RST)
         st_q <= ST_RUN;
      else
      begin
         unique case (st_q)
            ST_RUN:
               if (route_d.start_write)
                  st_q <= ST_HOLD;
            ST_HOLD:
               if (WRITE_DONE)
                  st_q <= ST_RUN;
            default:
               st_q <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         idle_q <= 1'b0;
      else
         idle_q <= (st_q == ST_RUN) ? route_d.start_write
                                    : ~WRITE_DONE;
   end
   assign CPU_IDLE_REQ = idle_q;
endmodule : pmd_top

// ==== tb/pmd_assertions.sv ====
// Port checker for the decode block
`timescale 1ns/1ps
module pmd_chk
   import pmd_pkg::*;
#(
   parameter bit BIG_PART = 1'b1
)
(
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       FUSE_CODE_WRITE,
   input wire pmd_req_s   CPU_REQ,
   input wire logic       WRITE_DONE,
   input wire pmd_route_s ROUTE,
   input wire logic       CPU_IDLE_REQ
);
   logic [15:0] top;
   assign top = BIG_PART ? CODE_TOP_BIG : CODE_TOP_SML;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   idle_cause_a:
      assert property ($rose(CPU_IDLE_REQ) |-> ROUTE.start_write)
      else $error("idle without store");
   idle_stay_a:
      assert property (CPU_IDLE_REQ && !WRITE_DONE |=> CPU_IDLE_REQ)
      else $error("idle dropped early");
   idle_free_a:
      assert property (CPU_IDLE_REQ && WRITE_DONE |=> !CPU_IDLE_REQ)
      else $error("idle not released");
   store_space_a:
      assert property (ROUTE.start_write |-> ROUTE.space inside
         {SPC_CODE, SPC_SIG}) else $error("store to wrong space");
   fuse_block_a:
      assert property (!FUSE_CODE_WRITE [*2] |=> !ROUTE.start_write)
      else $error("store with fuse off");
   high_data_a:
      assert property (CPU_REQ.valid && !CPU_REQ.is_code_read &&
         CPU_REQ.addr > top |=> ROUTE.space == SPC_EXT_DATA)
      else $error("high data move");
   high_code_a:
      assert property (CPU_REQ.valid && CPU_REQ.is_code_read &&
         CPU_REQ.addr > top |=> ROUTE.space inside {SPC_EXT_CODE, SPC_SIG})
      else $error("high code read");
   reset_clear_a:
      assert property (disable iff (1'b0) RST |=> !CPU_IDLE_REQ &&
         ROUTE.space == SPC_EXT_DATA) else $error("reset state");
endmodule : pmd_chk
bind pmd_top pmd_chk #(.BIG_PART(BIG_PART)) chk_u (.*);

// ==== tb/pmd_cpu_model.sv ====
// Behavioural core issuing data moves and code reads
`timescale 1ns/1ps
module pmd_cpu
   import pmd_pkg::*;
(
   input  wire logic clk,
   input  wire logic idle,
   output pmd_req_s  req
);
   initial req = '0;
   task acc(input logic c, w, input logic [15:0] a);
      while (idle === 1'b1) @(posedge clk);
      req <= '{1'b1, c, w, a};
      @(posedge clk);
      req.valid <= 1'b0;
   endtask : acc
endmodule : pmd_cpu

// ==== tb/tb_top.sv ====
// Bench for the decode block
`timescale 1ns/1ps
module tb_top
   import pmd_pkg::*;
;
   logic       clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
   logic       fuse = 1'b1, done = 1'b0, idle, wq;
   logic [7:0] adr = 8'h00, wd = 8'h00, rdat, q;
   pmd_req_s   req;
   pmd_route_s rt;
   int         n_fail = 0, n_tests = 0;
   logic [15:0] al[5] = '{16'h0000, 16'h00FF, 16'h0100, 16'h1FFF, 16'h2000};
   always #12.5 clk = ~clk;
   pmd_top dut_u (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq), .FUSE_CODE_WRITE(fuse), .CPU_REQ(req),
      .WRITE_DONE(done), .ROUTE(rt), .CPU_IDLE_REQ(idle));
   pmd_cpu cpu_u (.clk(clk), .idle(idle), .req(req));
   task chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, g, e);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, d);
      int i;
      i = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (wq !== 1'b0 && i < 9);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
      if (i == 9) n_fail++;
   endtask : bus
   function automatic pmd_space_e sp(logic [7:0] r, logic c, logic [15:0] a);
      if (c)
         return r[SIG_BIT] ? SPC_SIG :
            (a > CODE_TOP_BIG ? SPC_EXT_CODE : SPC_CODE);
      if (r[CWE_BIT] && a <= CODE_TOP_BIG)
         return r[SIG_BIT] ? SPC_SIG : SPC_CODE;
      return (r[DFE_BIT] && !r[CWE_BIT] && a <= DF_TOP) ? SPC_DATA_FL :
         SPC_EXT_DATA;
   endfunction : sp
   task t_regs;
      bus(1'b0, MAC_OFFSET, 8'h00);
      chk(q, 8'h00);
      fuse <= 1'b0;
      bus(1'b1, MAC_OFFSET, 8'hFF);
      bus(1'b0, MAC_OFFSET, 8'h00);
      chk(q, 8'h60);
      bus(1'b0, 8'h95, 8'h00);
      chk(q, 8'h00);
      fuse <= 1'b1;
   endtask : t_regs
   task t_map;
      for (int r = 0; r < 8; r++)
      begin
         bus(1'b1, MAC_OFFSET, 8'(r << 5));
         bus(1'b0, MAC_OFFSET, 8'h00);
         chk(q, 8'(r << 5));
         for (int k = 0; k < 10; k++)
         begin
            cpu_u.acc(k[0], 1'b0, al[k / 2]);
            @(posedge clk);
            chk(8'(rt.space), 8'(sp(8'(r << 5), k[0], al[k / 2])));
         end
      end
   endtask : t_map
   task t_iap;
      bus(1'b1, MAC_OFFSET, 8'h80);
      cpu_u.acc(1'b0, 1'b1, 16'h1FFF);
      @(posedge clk);
      chk(8'({rt.start_write, idle}), 8'h03);
      repeat (5) @(posedge clk);
      chk(8'(idle), 8'h01);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(posedge clk);
      chk(8'(idle), 8'h00);
      bus(1'b1, MAC_OFFSET, 8'hC0);
      cpu_u.acc(1'b0, 1'b1, 16'h0000);
      @(posedge clk);
      chk(8'(rt.space), 8'(SPC_SIG));
      // Reset in mid-write must also drop the hold
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(8'(idle), 8'h00);
      bus(1'b0, MAC_OFFSET, 8'h00);
      chk(q, 8'h00);
   endtask : t_iap
   task give_verdict;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_map;
      t_iap;
      give_verdict;
   end
   initial
   begin
      #50us;
      n_fail++;
      give_verdict;
   end
endmodule : tb_top
